/* src/pfw_pkg.sv */
// shared constants for the foldback, policing and bus watchdog register bank
package pfw_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned WDOG_TIMEOUT_MS = 2000;
  localparam int unsigned LIMIT_FAULT_TIME_NOM_MS = 60;
  // cycle counts are exact products at this clock, so no rounding creeps in
  localparam int unsigned WDOG_CYCLES = WDOG_TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned LIMIT_FAULT_TIME_NOM_CYCLES = LIMIT_FAULT_TIME_NOM_MS * CLK_KHZ;
  localparam int unsigned TIMER_W = 28;
  // ==========================================================
  // command codes (register addresses on the serial bus)
  localparam logic [7:0] CMD_FOLDBACK_POLICING = 8'h40;
  localparam logic [7:0] CMD_FIRMWARE_VERSION = 8'h41;
  localparam logic [7:0] CMD_BUS_WATCHDOG = 8'h42;
  localparam logic [7:0] CMD_CH_VOLTAGE_BASE = 8'h32;
  localparam logic [7:0] CMD_CH_VOLTAGE_STEP = 8'h04;
  // ==========================================================
  // field layout and reset values
  localparam int unsigned FB_LSB = 4;
  localparam int unsigned HOLD_LSB = 0;
  localparam int unsigned WDS_BIT = 0;
  localparam int unsigned KEY_LSB = 1;
  localparam logic [7:0] FOLDBACK_POLICING_RST = 8'h00;
  localparam logic [7:0] FW_VERSION_RST = 8'h00;
  localparam logic [7:0] FW_SAFE_MODE = 8'hff;
  localparam logic [3:0] WDOG_KEY_RST = 4'hb;
  localparam logic [3:0] WDOG_KEY_MASKED = 4'hb;
  localparam logic [3:0] CLASS_FOLDBACK_MIN = 4'h4;
  // ==========================================================
  // voltage result: 14-bit code, step 3.662 mV, full scale 60 V
  localparam int unsigned VCODE_W = 14;
  localparam int unsigned VSTEP_UV = 3662;
  localparam int unsigned VFULL_SCALE_V = 60;
  localparam logic [13:0] VCODE_RST = 14'h0000;
endpackage

/* src/pfw_regs.sv */
// foldback select, policing hold, firmware version, bus watchdog and voltage readout
// Function
// RQ1: channel voltage is 14-bit read-only, fetched as one two-byte read
// RQ2: powered channel reports voltage code N, 3.662 mV per step, 60 V full scale
// RQ3: foldback select bit raises the channel's current and short thresholds; only current_limit_threshold_boost is driven, no short threshold
// RQ4: fault timer starts when port current exceeds the current limit threshold
// RQ5: inrush profile at turn-on ignores the foldback select bit
// RQ6: foldback clear uses nominal 60 ms fault time, set uses programmed time
// RQ7: turn-on sets foldback select for assigned class 4 or higher
// RQ8: single-signature four-pair sets both bits; dual-signature sets each by class
// RQ9: hold bit 0 lets turn-on adjust power cut and foldback; 1 leaves them
// RQ10: every turn-off restores power cut and foldback select to defaults
// RQ11: on four-pair ports either hold bit suppresses auto setup on both channels
// RQ12: turn-off clears the channel's hold bit
// RQ13: on four-pair ports each foldback bit governs only its own channel
// RQ14: version reads zero after reset, loaded value 0x01 to 0xfe after load
// RQ15: version 0xff means safe mode; host must reload the memory
// RQ16: either edge on the serial clock restarts the watchdog timer
// RQ17: watchdog expiry turns all channels off and sets the expired flag
// RQ18: watchdog expires after 2 seconds without a serial clock edge
// RQ19: key 1011b masks channel shutdown; expiry then only sets the flag
// RQ20: expired flag stays set until the host writes 0 to it
// RQ21: an off channel's voltage result reads zero
`timescale 1ns/1ps
module pfw_regs #(
  parameter int unsigned NCH = 4,
  parameter int unsigned WDOG_LIMIT = pfw_pkg::WDOG_CYCLES,
  parameter int unsigned LIMIT_FAULT_TIME_NOM = pfw_pkg::LIMIT_FAULT_TIME_NOM_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register command port from the serial bus engine
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic cmd_rd_first,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  output logic cmd_rvalid,
  // serial clock pin, watched by the watchdog
  input wire logic scl_in,
  // per-channel port state and events
  input wire logic [NCH-1:0] port_on,
  input wire logic [NCH-1:0] turn_on_evt,
  input wire logic [NCH-1:0] turn_off_evt,
  input wire logic [NCH-1:0] inrush_phase,
  input wire logic [NCH-1:0] over_current_limit_threshold,
  input wire logic [4*NCH-1:0] assigned_class,
  input wire logic [NCH/2-1:0] port_four_pair,
  input wire logic [NCH/2-1:0] port_single_sig,
  // voltage measurements
  input wire logic [NCH-1:0] adc_valid,
  input wire logic [pfw_pkg::VCODE_W*NCH-1:0] adc_code,
  // programmed fault time and firmware load status
  input wire logic [pfw_pkg::TIMER_W-1:0] limit_fault_time_prog_cycles,
  input wire logic fw_load_valid,
  input wire logic [7:0] fw_load_version,
  input wire logic fw_safe_mode,
  // outputs to the power stage
  output logic [NCH-1:0] current_limit_threshold_boost,
  output logic [NCH-1:0] power_cut_threshold_from_class,
  output logic [NCH-1:0] limit_fault,
  output logic all_channels_off
);
  import pfw_pkg::*;

  // ==========================================================
  // state
  logic [NCH-1:0] fb_reg, fb_next;
  logic [NCH-1:0] hold_reg, hold_next;
  logic [NCH-1:0] power_cut_threshold_reg, power_cut_threshold_next;
  logic [7:0] fw_reg;
  logic [3:0] key_reg;
  logic wds_reg;
  logic [VCODE_W-1:0] volt_reg [NCH];
  logic [VCODE_W-1:0] snap_reg;
  logic [1:0] scl_sync_reg;
  logic scl_last_reg;
  logic [TIMER_W-1:0] wdog_cnt_reg;
  logic wdog_expire;
  logic wdog_shut;
  logic scl_edge;
  logic [7:0] rd_byte;
  logic [VCODE_W-1:0] vsel;
  logic vhit;

  // ==========================================================
  // watchdog: two-flop synchroniser, then edge detect on the second flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // reset to the pulled-up idle level so no false edge follows reset
      scl_sync_reg <= 2'b11;
      scl_last_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      scl_last_reg <= scl_sync_reg[1];
    end
  end
  assign scl_edge = scl_sync_reg[1] ^ scl_last_reg; // [RQ16]

  // counter restarts on any edge; it stops at the limit so expiry fires once per idle spell
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wdog_cnt_reg <= '0;
    end else if (scl_edge) begin
      wdog_cnt_reg <= '0; // [RQ16]
    end else if (wdog_cnt_reg < TIMER_W'(WDOG_LIMIT)) begin
      wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
    end
  end
  assign wdog_expire = !scl_edge && (wdog_cnt_reg == TIMER_W'(WDOG_LIMIT - 1)); // [RQ18]
  assign wdog_shut = wdog_expire && (key_reg != WDOG_KEY_MASKED); // [RQ19]

  // shutdown request is a one-cycle pulse, registered
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      all_channels_off <= 1'b0;
    end else begin
      all_channels_off <= wdog_shut; // [RQ17]
    end
  end

  // watchdog register: key is plain storage, flag is sticky and set wins over clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      key_reg <= WDOG_KEY_RST;
      wds_reg <= 1'b0;
    end else begin
      if (cmd_wr && cmd_code == CMD_BUS_WATCHDOG) begin
        key_reg <= cmd_wdata[KEY_LSB +: 4];
      end
      if (wdog_expire) begin
        wds_reg <= 1'b1; // [RQ17]
      end else if (cmd_wr && cmd_code == CMD_BUS_WATCHDOG && !cmd_wdata[WDS_BIT]) begin
        wds_reg <= 1'b0; // [RQ20]
      end
    end
  end

  // ==========================================================
  // foldback select, policing hold and power-cut source
  // hardware events override a same-cycle host write, since turn-off must win
  always_comb begin
    logic auto_ok;
    logic cls_hi;
    int p;
    auto_ok = 1'b0;
    cls_hi = 1'b0;
    p = 0;
    fb_next = fb_reg;
    hold_next = hold_reg;
    power_cut_threshold_next = power_cut_threshold_reg;
    if (cmd_wr && cmd_code == CMD_FOLDBACK_POLICING) begin
      fb_next = cmd_wdata[FB_LSB +: NCH];
      hold_next = cmd_wdata[HOLD_LSB +: NCH];
    end
    for (int i = 0; i < NCH; i++) begin
      p = i / 2;
      // a four-pair port is suppressed if either channel holds
      auto_ok = port_four_pair[p] ? !(hold_reg[i] || hold_reg[i ^ 1]) : !hold_reg[i]; // [RQ11]
      // single signature: both channels follow the lower channel's class
      if (port_four_pair[p] && port_single_sig[p]) begin
        cls_hi = assigned_class[4*(2*p) +: 4] >= CLASS_FOLDBACK_MIN; // [RQ8]
      end else begin
        cls_hi = assigned_class[4*i +: 4] >= CLASS_FOLDBACK_MIN; // [RQ7]
      end
      if (turn_on_evt[i] && auto_ok) begin
        fb_next[i] = cls_hi; // [RQ9]
        power_cut_threshold_next[i] = 1'b1; // [RQ9]
      end
      if (turn_off_evt[i] || wdog_shut) begin
        fb_next[i] = 1'b0; // [RQ10]
        power_cut_threshold_next[i] = 1'b0; // [RQ10]
        hold_next[i] = 1'b0; // [RQ12]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fb_reg <= FOLDBACK_POLICING_RST[FB_LSB +: NCH];
      hold_reg <= FOLDBACK_POLICING_RST[HOLD_LSB +: NCH];
      power_cut_threshold_reg <= '0;
    end else begin
      fb_reg <= fb_next;
      hold_reg <= hold_next;
      power_cut_threshold_reg <= power_cut_threshold_next;
    end
  end

  // boost is held back during inrush so turn-on current looks the same either way
  assign current_limit_threshold_boost = fb_reg & ~inrush_phase; // [RQ3] [RQ5] [RQ13]
  assign power_cut_threshold_from_class = power_cut_threshold_reg;

  // ==========================================================
  // per-channel fault timer and voltage result
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [TIMER_W-1:0] flt_cnt_reg;
    logic [TIMER_W-1:0] flt_limit;
    // nominal time unless foldback is selected for this channel alone
    assign flt_limit = fb_reg[g] ? limit_fault_time_prog_cycles : TIMER_W'(LIMIT_FAULT_TIME_NOM); // [RQ6] [RQ13]

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        flt_cnt_reg <= '0;
        limit_fault[g] <= 1'b0;
      end else if (over_current_limit_threshold[g] && port_on[g]) begin
        if (flt_cnt_reg < flt_limit) begin
          flt_cnt_reg <= flt_cnt_reg + 1'b1; // [RQ4]
        end
        limit_fault[g] <= (flt_cnt_reg + 1'b1) >= flt_limit;
      end else begin
        flt_cnt_reg <= '0;
        limit_fault[g] <= 1'b0;
      end
    end

    // stale readings would mislead software, so an off channel reads zero
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        volt_reg[g] <= VCODE_RST;
      end else if (!port_on[g]) begin
        volt_reg[g] <= VCODE_RST; // [RQ21]
      end else if (adc_valid[g]) begin
        volt_reg[g] <= adc_code[VCODE_W*g +: VCODE_W]; // [RQ2]
      end
    end
  end

  // ==========================================================
  // firmware version: zero after reset, load value, or safe-mode code
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fw_reg <= FW_VERSION_RST; // [RQ14]
    end else if (fw_safe_mode) begin
      fw_reg <= FW_SAFE_MODE; // [RQ15]
    end else if (fw_load_valid) begin
      fw_reg <= fw_load_version; // [RQ14]
    end
  end

  // ==========================================================
  // read path: the first byte of a voltage read snapshots all 14 bits
  // so the high byte always matches the low byte even if a new sample lands
  always_comb begin
    vsel = VCODE_RST;
    vhit = 1'b0;
    rd_byte = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      if (cmd_code == CMD_CH_VOLTAGE_BASE + 8'(i) * CMD_CH_VOLTAGE_STEP) begin
        vsel = volt_reg[i];
        vhit = 1'b1;
      end
    end
    if (vhit) begin
      if (cmd_rd_first) begin
        rd_byte = vsel[7:0]; // [RQ1]
      end else begin
        rd_byte = {2'b00, snap_reg[VCODE_W-1:8]}; // [RQ1]
      end
    end else if (cmd_code == CMD_FOLDBACK_POLICING) begin
      rd_byte = 8'({fb_reg, hold_reg});
    end else if (cmd_code == CMD_FIRMWARE_VERSION) begin
      rd_byte = fw_reg;
    end else if (cmd_code == CMD_BUS_WATCHDOG) begin
      rd_byte = {3'b000, key_reg, wds_reg};
    end
  end

  // unmapped codes read as zero; read data holds until the next read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_rdata <= 8'h00;
      cmd_rvalid <= 1'b0;
      snap_reg <= VCODE_RST;
    end else begin
      cmd_rvalid <= cmd_rd;
      if (cmd_rd) begin
        cmd_rdata <= rd_byte;
        if (vhit && cmd_rd_first) begin
          snap_reg <= vsel; // [RQ1]
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wdog_flag_set_a: assert property (wdog_expire |=> wds_reg) // [RQ17]
    else $error("expired flag not set after watchdog expiry");
  wdog_shut_mask_a: assert property (wdog_expire && key_reg == 4'hb |=> !all_channels_off) // [RQ19]
    else $error("masked watchdog still turned channels off");
  wdog_shut_on_a: assert property (wdog_expire && key_reg != 4'hb |=> all_channels_off) // [RQ17]
    else $error("unmasked watchdog expiry did not shut channels");
  wdog_edge_restart_a: assert property (scl_edge |=> wdog_cnt_reg == '0) // [RQ16]
    else $error("serial clock edge did not restart watchdog");
  wds_sticky_a: assert property (wds_reg && !(cmd_wr && cmd_code == 8'h42) |=> wds_reg) // [RQ20]
    else $error("expired flag dropped without host clear");
  turn_off_clear_a: assert property (turn_off_evt[0] |=> !fb_reg[0] && !hold_reg[0] && !power_cut_threshold_reg[0]) // [RQ10]
    else $error("turn-off left foldback, hold or power cut set");
  hold_keeps_fb_a: assert property (turn_on_evt[0] && hold_reg[0] && !turn_off_evt[0]
      && !wdog_shut && !cmd_wr |=> fb_reg[0] == $past(fb_reg[0])) // [RQ9]
    else $error("held channel foldback changed at turn-on");
  class_auto_fb_a: assert property (turn_on_evt[0] && !port_four_pair[0] && !hold_reg[0]
      && !turn_off_evt[0] && !wdog_shut && assigned_class[3:0] >= 4'h4 |=> fb_reg[0]) // [RQ7]
    else $error("class 4 turn-on did not set foldback");
  inrush_no_boost_a: assert property (inrush_phase[0] |-> !current_limit_threshold_boost[0]) // [RQ5]
    else $error("limit boosted during inrush");
  off_volt_zero_a: assert property (!port_on[0] |=> volt_reg[0] == '0) // [RQ21]
    else $error("off channel voltage not zero");
  fw_reset_zero_a: assert property ($rose(rst_n) |-> fw_reg == 8'h00) // [RQ14]
    else $error("firmware version not zero after reset");
  volt_msb_a: assert property (cmd_rd && !cmd_rd_first && cmd_code == 8'h32
      |=> cmd_rdata == {2'b00, $past(snap_reg[13:8])} && cmd_rvalid) // [RQ1]
    else $error("voltage high byte does not match snapshot");

  wdog_expiry_c: cover property (wdog_expire ##1 all_channels_off);
  auto_fb_c: cover property (turn_on_evt[0] ##1 fb_reg[0]);
  volt_read_c: cover property (cmd_rd && cmd_rd_first && cmd_code == 8'h32 ##2 cmd_rd);
  flag_clear_c: cover property (wds_reg ##1 !wds_reg);
endmodule // pfw_regs

/* verification/pfw_host_model.sv */
// host side model: drives register commands and the serial clock pin
`timescale 1ns/1ps
module pfw_host_model (
  // clock
  core_clk,
  // register command port
  cmd_wr,
  cmd_rd,
  cmd_rd_first,
  cmd_code,
  cmd_wdata,
  cmd_rdata,
  cmd_rvalid,
  // serial clock pin, idles high through its pull-up
  scl
);
  input wire logic core_clk;
  output logic cmd_wr;
  output logic cmd_rd;
  output logic cmd_rd_first;
  output logic [7:0] cmd_code;
  output logic [7:0] cmd_wdata;
  input wire logic [7:0] cmd_rdata;
  input wire logic cmd_rvalid;
  output logic scl;
  // ==========================================================
  // idle state at time zero
  initial begin
    {cmd_wr, cmd_rd, cmd_rd_first, cmd_code, cmd_wdata} = '0;
    scl = 1'b1;
  end
  // one-byte write; released data is inverted so stale bytes never look valid
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge core_clk);
    #1;
    {cmd_wr, cmd_code, cmd_wdata} = {1'b1, code, data};
    @(posedge core_clk);
    #1;
    {cmd_wr, cmd_wdata} = {1'b0, ~data};
  endtask
  // one-byte read; a voltage result is two of these with the same code
  task automatic rd(input logic [7:0] code, input logic first, output logic [7:0] data,
                    output logic ok);
    @(posedge core_clk);
    #1;
    {cmd_rd, cmd_rd_first, cmd_code} = {1'b1, first, code};
    @(posedge core_clk);
    #1;
    cmd_rd = 1'b0;
    ok = cmd_rvalid;
    data = cmd_rdata;
  endtask
  // serial clock activity, one edge per cycle; an even count leaves it high
  task automatic scl_run(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      scl = ~scl;
    end
  endtask
endmodule // pfw_host_model

/* verification/pse_foldback_watchdog_regs_test.sv */
// self-checking testbench for the foldback, policing and watchdog register bank
`timescale 1ns/1ps
module pse_foldback_watchdog_regs_test;
  import pfw_pkg::*;
  localparam int unsigned WDL = 50;
  localparam int unsigned TLN = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_wr, cmd_rd, cmd_rd_first, cmd_rvalid, scl_in, all_channels_off;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata;
  logic [3:0] port_on, turn_on_evt, turn_off_evt, inrush_phase, over_current_limit_threshold, adc_valid;
  logic [3:0] current_limit_threshold_boost, power_cut_threshold_from_class, limit_fault;
  logic [15:0] assigned_class;
  logic [1:0] port_four_pair, port_single_sig;
  logic [55:0] adc_code;
  logic [27:0] limit_fault_time_prog_cycles;
  logic fw_load_valid, fw_safe_mode;
  logic [7:0] fw_load_version;
  int n_errors = 0;
  int tests_run = 0;
  int n_off = 0;
  int n;
  // ==========================================================
  // clock, partner and design
  always #4 core_clk = ~core_clk;
  pfw_host_model host_inst (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_rd_first(cmd_rd_first), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .scl(scl_in));
  pfw_regs #(.NCH(4), .WDOG_LIMIT(WDL), .LIMIT_FAULT_TIME_NOM(TLN)) pfw_regs_inst (.core_clk(core_clk),
    .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rd_first(cmd_rd_first),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .scl_in(scl_in), .port_on(port_on), .turn_on_evt(turn_on_evt), .turn_off_evt(turn_off_evt),
    .inrush_phase(inrush_phase), .over_current_limit_threshold(over_current_limit_threshold), .assigned_class(assigned_class),
    .port_four_pair(port_four_pair), .port_single_sig(port_single_sig), .adc_valid(adc_valid),
    .adc_code(adc_code), .limit_fault_time_prog_cycles(limit_fault_time_prog_cycles), .fw_load_valid(fw_load_valid),
    .fw_load_version(fw_load_version), .fw_safe_mode(fw_safe_mode), .current_limit_threshold_boost(current_limit_threshold_boost),
    .power_cut_threshold_from_class(power_cut_threshold_from_class), .limit_fault(limit_fault),
    .all_channels_off(all_channels_off));
  // counts shutdown pulses; sampled a full cycle after they launch
  always @(posedge core_clk) if (all_channels_off === 1'b1) n_off++;
  // ==========================================================
  // shared helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] code, input logic first, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_inst.rd(code, first, d, v);
    check(16'(v), 16'h0001);
    check(16'(d), 16'(exp));
  endtask
  // pulses turn-on or turn-off on every channel, then lets the effect land
  task automatic events(input logic on);
    if (on) turn_on_evt = 4'hf;
    else turn_off_evt = 4'hf;
    step(1);
    {turn_on_evt, turn_off_evt} = '0;
    step(1);
  endtask
  // cycles from over-limit until the fault shows on channel 0
  task automatic fault_time(output int k);
    k = 0;
    over_current_limit_threshold = 4'h1;
    while (limit_fault[0] !== 1'b1 && k < 200) begin
      step(1);
      k++;
    end
    over_current_limit_threshold = 4'h0;
    step(2);
    check(16'(limit_fault[0]), 16'h0000);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_values;
    rdchk(CMD_FOLDBACK_POLICING, 1'b0, 8'h00);
    rdchk(CMD_FIRMWARE_VERSION, 1'b0, 8'h00);
    rdchk(CMD_BUS_WATCHDOG, 1'b0, 8'h16);
    rdchk(8'h50, 1'b0, 8'h00);
    check(16'({current_limit_threshold_boost, power_cut_threshold_from_class, limit_fault}), 16'h0000);
  endtask
  task automatic t_voltage;
    port_on = 4'hf;
    for (int i = 0; i < 4; i++) adc_code[14*i +: 14] = 14'h3fff - 14'(i * 14'h1543);
    adc_valid = 4'hf;
    step(1);
    adc_valid = 4'h0;
    for (int i = 0; i < 4; i++) begin
      rdchk(CMD_CH_VOLTAGE_BASE + 8'(4 * i), 1'b1, adc_code[14*i +: 8]);
      rdchk(CMD_CH_VOLTAGE_BASE + 8'(4 * i), 1'b0, {2'b00, adc_code[14*i+8 +: 6]});
    end
    port_on = 4'h0;
    step(2);
    rdchk(8'h36, 1'b1, 8'h00);
    rdchk(8'h36, 1'b0, 8'h00);
    host_inst.wr(8'h36, 8'h5a);
    rdchk(8'h36, 1'b1, 8'h00);
  endtask
  task automatic t_auto_config;
    assigned_class = 16'h4435;
    host_inst.wr(CMD_FOLDBACK_POLICING, 8'h08);
    events(1'b1);
    rdchk(CMD_FOLDBACK_POLICING, 1'b0, 8'h58);
    check(16'(power_cut_threshold_from_class), 16'h0007);
    events(1'b0);
    rdchk(CMD_FOLDBACK_POLICING, 1'b0, 8'h00);
    check(16'(power_cut_threshold_from_class), 16'h0000);
    {port_four_pair, port_single_sig, assigned_class} = {2'b11, 2'b01, 16'h2604};
    host_inst.wr(CMD_FOLDBACK_POLICING, 8'h01);
    events(1'b1);
    rdchk(CMD_FOLDBACK_POLICING, 1'b0, 8'h41);
    host_inst.wr(CMD_FOLDBACK_POLICING, 8'h00);
    events(1'b1);
    rdchk(CMD_FOLDBACK_POLICING, 1'b0, 8'h70);
    check(16'(current_limit_threshold_boost), 16'h0007);
    inrush_phase = 4'h5;
    step(1);
    check(16'(current_limit_threshold_boost), 16'h0002);
    inrush_phase = 4'h0;
    events(1'b0);
  endtask
  task automatic t_fault_timer;
    port_on = 4'h1;
    limit_fault_time_prog_cycles = 28'd8;
    fault_time(n);
    check(16'(n >= TLN - 1 && n <= TLN + 2), 16'h0001);
    host_inst.wr(CMD_FOLDBACK_POLICING, 8'h10);
    fault_time(n);
    check(16'(n >= 7 && n <= 10), 16'h0001);
    port_on = 4'h0;
  endtask
  task automatic t_firmware;
    host_inst.wr(CMD_FIRMWARE_VERSION, 8'h55);
    rdchk(CMD_FIRMWARE_VERSION, 1'b0, 8'h00);
    {fw_load_valid, fw_load_version} = {1'b1, 8'h37};
    step(1);
    fw_load_valid = 1'b0;
    rdchk(CMD_FIRMWARE_VERSION, 1'b0, 8'h37);
    fw_safe_mode = 1'b1;
    step(1);
    rdchk(CMD_FIRMWARE_VERSION, 1'b0, FW_SAFE_MODE);
    fw_safe_mode = 1'b0;
  endtask
  task automatic t_watchdog;
    host_inst.scl_run(4);
    host_inst.wr(CMD_BUS_WATCHDOG, 8'h16);
    rdchk(CMD_BUS_WATCHDOG, 1'b0, 8'h16);
    step(WDL + 20);
    rdchk(CMD_BUS_WATCHDOG, 1'b0, 8'h17);
    check(16'(n_off), 16'h0000);
    host_inst.wr(CMD_BUS_WATCHDOG, 8'h17);
    rdchk(CMD_BUS_WATCHDOG, 1'b0, 8'h17);
    host_inst.wr(CMD_BUS_WATCHDOG, 8'h00);
    host_inst.wr(CMD_FOLDBACK_POLICING, 8'h3c);
    host_inst.scl_run(120);
    check(16'(n_off), 16'h0000);
    n = 0;
    while (all_channels_off !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    check(16'(n >= WDL - 2 && n <= WDL + 4), 16'h0001);
    rdchk(CMD_BUS_WATCHDOG, 1'b0, 8'h01);
    rdchk(CMD_FOLDBACK_POLICING, 1'b0, 8'h00);
    check(16'(n_off), 16'h0001);
    host_inst.wr(CMD_BUS_WATCHDOG, 8'h16);
  endtask
  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {port_on, turn_on_evt, turn_off_evt, inrush_phase, over_current_limit_threshold, adc_valid} = '0;
    {assigned_class, port_four_pair, port_single_sig, adc_code} = '0;
    {limit_fault_time_prog_cycles, fw_load_valid, fw_safe_mode, fw_load_version} = '0;
    step(10);
    rst_n = 1'b1;
    t_reset_values();
    t_voltage();
    t_auto_config();
    t_fault_timer();
    t_firmware();
    t_watchdog();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    test_done();
  end
endmodule // pse_foldback_watchdog_regs_test
